// >>> design/audio_path_config_decode.sv
// Serial-loaded path configuration registers and their analog control decode.
`timescale 1ns/1ps
`default_nettype none

module audio_path_config_decode (
  input  wire logic                  i_clk_sys,
  input  wire logic                  i_reset_n,
  input  wire logic                  i_scl,
  input  wire logic                  i_sda,
  input  wire logic                  i_cfg_frame,
  input  wire logic                  i_cfg_sel_b,
  output var  audio_path_pkg::ctrl_t o_ctrl,
  output var  logic                  o_pending_a,
  output var  logic                  o_load_done
);

  // Synchronised pins; the serial clock is only sampled, never a clock.
  audio_path_pkg::link_t link;

  pin_sync #(
    .WIDTH (4)
  ) u_sync (
    .i_clk_sys (i_clk_sys),
    .i_reset_n (i_reset_n),
    .i_async   ({i_scl, i_sda, i_cfg_frame, i_cfg_sel_b}),
    .o_sync    (link)
  );

  // Whole module state in one record.
  typedef struct packed {
    logic                  scl_q;     // Previous serial clock sample.
    logic [15:0]           shift;     // Bits of the word in flight.
    logic [4:0]            count;     // Bits taken in this frame.
    logic                  pend_a;    // A complete word a awaits word b.
    logic [15:0]           stage_a;   // That staged word a.
    logic [15:0]           cfg_a;     // Applied register a.
    logic [15:0]           cfg_b;     // Applied register b.
    audio_path_pkg::ctrl_t ctrl;      // Applied controls.
    logic                  done;      // One-cycle pulse on apply.
  } st_t;

  st_t st;       // Registered state.
  st_t next_st;  // Next state.

  logic        scl_rise;  // Detected serial clock rising edge.
  logic        last_bit;  // This edge completes a word.
  logic [15:0] word;      // The completed word.

  // Turn two raw registers into the analog path controls.
  function automatic audio_path_pkg::ctrl_t decode(
    input logic [15:0] a,
    input logic [15:0] b
  );
    audio_path_pkg::ctrl_t c;
    c.gain_amp_powerdown = b[audio_path_pkg::B_GAIN_PD];            // [R8] [R20]
    c.filter_powerdown   = b[audio_path_pkg::B_FILTER_PD];          // [R4] [R20]
    case ({b[audio_path_pkg::B_RATE1], b[audio_path_pkg::B_RATE0]}) // [R5]
      2'h0:    c.rate_sel = audio_path_pkg::RATE_8K0;
      2'h1:    c.rate_sel = audio_path_pkg::RATE_6K4;
      2'h2:    c.rate_sel = audio_path_pkg::RATE_5K3;
      default: c.rate_sel = audio_path_pkg::RATE_UNDEF;
    endcase
    c.filter_source_sel  = b[audio_path_pkg::B_FILTER_SRC];
    c.filter_from_array  = b[audio_path_pkg::B_FILTER_SRC];         // [R3]
    c.filter_only_to_second_mixer =
      !b[audio_path_pkg::B_MIX2_MODE0] &&
      b[audio_path_pkg::B_MIX2_MODE1];                              // [R6]
    c.first_mix_takes_source =
      b[audio_path_pkg::B_MIX1_MODE0] &&
      !b[audio_path_pkg::B_MIX1_MODE1];                             // [R2]
    c.first_mix_takes_selector =
      !b[audio_path_pkg::B_MIX1_MODE0] &&
      b[audio_path_pkg::B_MIX1_MODE1];                              // [R2]
    c.line_to_first_mixer =
      !b[audio_path_pkg::B_MIX1_SRC0] &&
      !b[audio_path_pkg::B_MIX1_SRC1];                              // [R1]
    c.input_source_sel     = a[audio_path_pkg::A_INPUT_SEL];
    c.gain_amp_to_selector = !a[audio_path_pkg::A_INPUT_SEL];       // [R9]
    // The array has no other source, whatever the fields say.
    c.array_in_from_second_mixer = 1'b1;                            // [R7]
    c.attenuation =
      b[audio_path_pkg::B_ATTEN_HI:audio_path_pkg::B_ATTEN_LO];     // [R12]
    c.second_mixer_to_level =
      b[audio_path_pkg::B_LEVEL_SRC0] &&
      !b[audio_path_pkg::B_LEVEL_SRC1];                             // [R10]
    c.level_stage_powerdown = a[audio_path_pkg::A_LEVEL_PD];        // [R11]
    c.level_to_output =
      !a[audio_path_pkg::A_OUT_SRC0] &&
      !a[audio_path_pkg::A_OUT_SRC1];                               // [R13]
    c.speaker_high_gain_aux_down =
      a[audio_path_pkg::A_SPK_MODE0] &&
      !a[audio_path_pkg::A_SPK_MODE1];                              // [R14]
    return c;
  endfunction

  assign scl_rise = link.scl && !st.scl_q;
  assign last_bit = scl_rise && link.frame &&
                    (st.count == audio_path_pkg::LAST_BIT);
  assign word     = {st.shift[14:0], link.sda};

  // Shift bits in, stage word a, apply b and any staged word a on word b's last edge.
  always_comb begin
    next_st       = st;
    next_st.scl_q = link.scl;
    next_st.done  = 1'b0;
    if (!link.frame) begin
      // Between frames the bit counter restarts; a partial word is lost.
      next_st.count = '0;
    end else if (scl_rise && st.count != audio_path_pkg::FULL_CNT) begin
      next_st.shift = word;
      next_st.count = st.count + 5'h01;
      if (last_bit) begin
        if (link.sel_b) begin
          // Apply on the rising serial edge of the last bit of b.
          next_st.cfg_b  = word;                                    // [R17]
          next_st.cfg_a  = st.pend_a ? st.stage_a : st.cfg_a;       // [R15]
          next_st.pend_a = 1'b0;
          next_st.ctrl   = decode(next_st.cfg_a, word);             // [R19]
          next_st.done   = 1'b1;
        end else begin
          // Word a waits for b so the pair changes together.
          next_st.stage_a = word;                                   // [R16]
          next_st.pend_a  = 1'b1;
        end
      end
    end
  end

  // Synchronous reset leaves every stage powered down.
  always_ff @(posedge i_clk_sys) begin
    if (!i_reset_n) begin
      st.scl_q   <= 1'b0;
      st.shift   <= '0;
      st.count   <= '0;
      st.pend_a  <= 1'b0;
      st.stage_a <= audio_path_pkg::CFG_A_RESET;
      st.cfg_a   <= audio_path_pkg::CFG_A_RESET;
      st.cfg_b   <= audio_path_pkg::CFG_B_RESET;
      st.ctrl    <= decode(audio_path_pkg::CFG_A_RESET,
                           audio_path_pkg::CFG_B_RESET);
      st.done    <= 1'b0;
    end else begin
      st <= next_st;
    end
  end

  assign o_ctrl      = st.ctrl;
  assign o_pending_a = st.pend_a;
  assign o_load_done = st.done;

  // Checks on the decode and on when controls may move.
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_reset_n);

  a_apply_on_edge: assert property ( // [R17]
    !$stable(st.ctrl) |-> $past(last_bit) && $past(link.sel_b))
    else $error("controls changed without a completed b word");
  a_a_word_held: assert property ( // [R19]
    last_bit && !link.sel_b |=> $stable(st.ctrl) && st.pend_a)
    else $error("word a changed controls before word b");
  a_first_mix_line: assert property ( // [R1]
    st.ctrl.line_to_first_mixer == (st.cfg_b[10:9] == 2'h0))
    else $error("line input route wrong");
  a_first_mix_mode: assert property ( // [R2]
    st.ctrl.first_mix_takes_source == (st.cfg_b[8:7] == 2'h1) &&
    st.ctrl.first_mix_takes_selector == (st.cfg_b[8:7] == 2'h2))
    else $error("first mixer mode wrong");
  a_filter_src: assert property ( // [R3]
    st.ctrl.filter_from_array == st.cfg_b[4])
    else $error("filter source wrong");
  a_powerdown_high: assert property ( // [R20]
    st.ctrl.filter_powerdown == st.cfg_b[1] &&
    st.ctrl.gain_amp_powerdown == st.cfg_b[0] &&
    st.ctrl.level_stage_powerdown == st.cfg_a[0])
    else $error("power-down polarity wrong");
  // Each documented rate code must land on its own rate and no other.
  a_rate_decode: assert property ( // [R5]
    (st.cfg_b[3:2] == 2'h1) == (st.ctrl.rate_sel == audio_path_pkg::RATE_6K4) &&
    (st.cfg_b[3:2] == 2'h2) == (st.ctrl.rate_sel == audio_path_pkg::RATE_5K3) &&
    (st.cfg_b[3:2] == 2'h0) == (st.ctrl.rate_sel == audio_path_pkg::RATE_8K0))
    else $error("rate decode wrong");
  a_second_mix_mode: assert property ( // [R6]
    st.ctrl.filter_only_to_second_mixer == (st.cfg_b[6:5] == 2'h2))
    else $error("second mixer mode wrong");
  a_input_select: assert property ( // [R9]
    st.ctrl.gain_amp_to_selector == !st.cfg_a[9])
    else $error("input source select wrong");
  a_level_route: assert property ( // [R10]
    st.ctrl.second_mixer_to_level == (st.cfg_b[15:14] == 2'h1))
    else $error("level source route wrong");
  a_array_source: assert property ( // [R7]
    st.ctrl.array_in_from_second_mixer)
    else $error("array input not from second mixer");
  a_atten_field: assert property ( // [R12]
    o_load_done |-> st.ctrl.attenuation == $past(word[13:11]))
    else $error("attenuation not loaded");
  a_output_route: assert property ( // [R13]
    st.ctrl.level_to_output == (st.cfg_a[4:3] == 2'h0) &&
    st.ctrl.speaker_high_gain_aux_down == (st.cfg_a[2:1] == 2'h1))
    else $error("output or speaker decode wrong");

  c_load_a: cover property (last_bit && !link.sel_b);
  c_load_pair: cover property (st.pend_a ##[1:1000] o_load_done);
  c_load_b_only: cover property (!st.pend_a ##1 o_load_done);

endmodule // audio_path_config_decode

`default_nettype wire

// >>> shared/audio_path_pkg.sv
// Package for the audio-path configuration decode: fields, resets, types.
// Behaviour
// [R1] First-mix source 00 routes line amp in.
// [R2] First-mix mode 01 source, 10 selector only.
// [R3] Filter source bit: mixer at zero, array one.
// [R4] Filter power-down bit zero keeps filter up.
// [R5] Rate 01 6.4, 10 5.3, 00 8.0 kHz.
// [R6] Second-mix mode 10 passes filter output only.
// [R7] Storage array always fed by second mixer.
// [R8] Gain amp power-down zero powers amp up.
// [R9] Input source bit zero selects gain amp.
// [R10] Level source 01 routes second mixer in.
// [R11] Level stage power-down zero powers attenuator up.
// [R12] Three-bit binary attenuation, bit 11 least.
// [R13] Output source 00 routes level stage out.
// [R14] Speaker mode 01: high gain, aux down.
// [R15] Host may load only register b alone.
// [R16] Host loads register a before register b.
// [R17] New settings apply on serial clock rise.
// [R18] Host sends two registers as four bytes.
// [R19] Controls hold until a complete load ends.
// [R20] Power-down controls are active high.
package audio_path_pkg;

  // Register a (was the first register) field positions.
  localparam int A_LEVEL_PD   = 0;
  localparam int A_SPK_MODE0  = 1;
  localparam int A_SPK_MODE1  = 2;
  localparam int A_OUT_SRC0   = 3;
  localparam int A_OUT_SRC1   = 4;
  localparam int A_INPUT_SEL  = 9;

  // Register b field positions.
  localparam int B_GAIN_PD    = 0;
  localparam int B_FILTER_PD  = 1;
  localparam int B_RATE0      = 2;
  localparam int B_RATE1      = 3;
  localparam int B_FILTER_SRC = 4;
  localparam int B_MIX2_MODE0 = 5;
  localparam int B_MIX2_MODE1 = 6;
  localparam int B_MIX1_MODE0 = 7;
  localparam int B_MIX1_MODE1 = 8;
  localparam int B_MIX1_SRC0  = 9;
  localparam int B_MIX1_SRC1  = 10;
  localparam int B_ATTEN_LO   = 11;
  localparam int B_ATTEN_HI   = 13;
  localparam int B_LEVEL_SRC0 = 14;
  localparam int B_LEVEL_SRC1 = 15;

  // Word size and bits per word on the serial load.
  localparam int          WORD_BITS = 16;
  localparam logic [4:0]  LAST_BIT  = 5'h0F;
  localparam logic [4:0]  FULL_CNT  = 5'h10;

  // Reset values: every stage powered down, mixers off.
  localparam logic [15:0] CFG_A_RESET = 16'h0001;
  localparam logic [15:0] CFG_B_RESET = 16'h01E3;

  // Decoded sample rate.
  typedef enum logic [1:0] {
    RATE_8K0,
    RATE_6K4,
    RATE_5K3,
    RATE_UNDEF
  } rate_t;

  // Decoded analog path controls; power-downs are one for off.
  typedef struct packed {
    logic       gain_amp_powerdown;
    logic       filter_powerdown;
    rate_t      rate_sel;
    logic       filter_source_sel;
    logic       filter_from_array;
    logic       filter_only_to_second_mixer;
    logic       first_mix_takes_source;
    logic       first_mix_takes_selector;
    logic       line_to_first_mixer;
    logic       input_source_sel;
    logic       gain_amp_to_selector;
    logic       array_in_from_second_mixer;
    logic [2:0] attenuation;
    logic       second_mixer_to_level;
    logic       level_stage_powerdown;
    logic       level_to_output;
    logic       speaker_high_gain_aux_down;
  } ctrl_t;

  // Synchronised serial load pins.
  typedef struct packed {
    logic scl;
    logic sda;
    logic frame;
    logic sel_b;
  } link_t;

endpackage : audio_path_pkg

// >>> design/pin_sync.sv
// Two flip-flop synchroniser for a group of pins from outside the clock.
`timescale 1ns/1ps
`default_nettype none

module pin_sync #(
  parameter int WIDTH = 4
) (
  input  wire logic             i_clk_sys,
  input  wire logic             i_reset_n,
  input  wire logic [WIDTH-1:0] i_async,
  output var  logic [WIDTH-1:0] o_sync
);

  // All state: the first stage is read only by the second stage.
  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] stable;
  } sync_st_t;

  sync_st_t st;       // Registered state.
  sync_st_t next_st;  // Next state.

  // Shift the pins one stage per clock.
  always_comb begin
    next_st.meta   = i_async;
    next_st.stable = st.meta;
  end

  // Synchronous reset clears both stages.
  always_ff @(posedge i_clk_sys) begin
    if (!i_reset_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign o_sync = st.stable;

endmodule // pin_sync

`default_nettype wire

// >>> verification/cfg_host_model.sv
// Host model that loads configuration words over the serial load pins.
`timescale 1ns/1ps
`default_nettype none

module cfg_host_model (
  output var logic o_scl,
  output var logic o_sda,
  output var logic o_frame,
  output var logic o_sel_b
);
  // The serial clock stands low outside frames.
  // Non-blocking drives keep a change that lands on a clock edge race-free.
  initial begin
    o_scl <= 1'b0;
    o_sda <= 1'b1;
    o_frame <= 1'b0;
    o_sel_b <= 1'b0;
  end

  // Sends nbits, MSB first, at a 125 ns serial period.
  // Bits past the sixteenth are random filler, which the device must ignore.
  task automatic send_word(input logic sel, input logic [15:0] w,
                           input int nbits);
    o_sel_b <= sel;
    o_frame <= 1'b1;
    #40;
    for (int i = 0; i < nbits; i++) begin
      o_sda <= (i < 16) ? w[15-i] : 1'($urandom);
      #62.5 o_scl <= 1'b1;
      #62.5 o_scl <= 1'b0;
    end
    #40 o_frame <= 1'b0;
    // A released data line must not keep its last value.
    o_sda <= ~o_sda;
    #40;
  endtask
endmodule // cfg_host_model

`default_nettype wire

// >>> verification/tb_audio_path_config_decode.sv
// Self-checking testbench for the path configuration decode block.
`timescale 1ns/1ps
`default_nettype none

`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin bad_count++; \
  $display("BAD %s exp %h got %h", nm, e, g); end end

module tb_audio_path_config_decode;
  logic                  i_clk_sys;   // System clock, 4 ns.
  logic                  i_reset_n;   // Synchronous reset, active low.
  logic                  scl;         // Serial pins from the host model.
  logic                  sda;
  logic                  frame;
  logic                  sel_b;
  audio_path_pkg::ctrl_t o_ctrl;      // Decoded controls.
  logic                  o_pending_a; // Word a staged.
  logic                  o_load_done; // Load applied pulse.
  int                    bad_count;
  int                    n_tests;
  logic [15:0]           a_cur;       // Applied register a.
  logic [15:0]           b_cur;       // Applied register b.
  logic [15:0]           a_stg;       // Staged register a.
  logic                  pend;        // Expected staging flag.
  audio_path_pkg::ctrl_t exp_q[$];    // Expected loads in order.
  audio_path_pkg::ctrl_t exp_c;

  cfg_host_model i_host (.o_scl(scl), .o_sda(sda), .o_frame(frame),
                         .o_sel_b(sel_b));

  audio_path_config_decode i_dut (.i_clk_sys(i_clk_sys),
    .i_reset_n(i_reset_n), .i_scl(scl), .i_sda(sda), .i_cfg_frame(frame),
    .i_cfg_sel_b(sel_b), .o_ctrl(o_ctrl), .o_pending_a(o_pending_a),
    .o_load_done(o_load_done));

  // Reference decode of both registers into the expected controls.
  function automatic audio_path_pkg::ctrl_t decode(input logic [15:0] a,
                                                   input logic [15:0] b);
    audio_path_pkg::ctrl_t c;
    c.gain_amp_powerdown = b[0];
    c.filter_powerdown = b[1];
    case (b[3:2])
      2'b01:   c.rate_sel = audio_path_pkg::RATE_6K4;
      2'b10:   c.rate_sel = audio_path_pkg::RATE_5K3;
      2'b00:   c.rate_sel = audio_path_pkg::RATE_8K0;
      default: c.rate_sel = audio_path_pkg::RATE_UNDEF;
    endcase
    c.filter_source_sel = b[4];
    c.filter_from_array = b[4];
    c.filter_only_to_second_mixer = (b[6:5] == 2'b10);
    c.first_mix_takes_source = (b[8:7] == 2'b01);
    c.first_mix_takes_selector = (b[8:7] == 2'b10);
    c.line_to_first_mixer = (b[10:9] == 2'b00);
    c.input_source_sel = a[9];
    c.gain_amp_to_selector = ~a[9];
    c.array_in_from_second_mixer = 1'b1;
    c.attenuation = b[13:11];
    c.second_mixer_to_level = (b[15:14] == 2'b01);
    c.level_stage_powerdown = a[0];
    c.level_to_output = (a[4:3] == 2'b00);
    c.speaker_high_gain_aux_down = (a[2:1] == 2'b01);
    return c;
  endfunction

  // Prints the verdict and ends the run.
  task automatic end_sim();
    if (bad_count == 0 && n_tests > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // Notes the expected effect of one word, sends it, then checks the
  // steady state; a partial word must leave everything as it was.
  task automatic load(input logic sel, input logic [15:0] w, input int nbits);
    if (nbits >= 16 && !sel) begin
      a_stg = w;
      pend = 1'b1;
    end else if (nbits >= 16) begin
      if (pend) a_cur = a_stg;
      b_cur = w;
      pend = 1'b0;
      exp_q.push_back(decode(a_cur, b_cur));
    end
    i_host.send_word(sel, w, nbits);
    repeat (10) @(posedge i_clk_sys);
    `CHK("pending_a", pend, o_pending_a)
    `CHK("ctrl_hold", decode(a_cur, b_cur), o_ctrl)
  endtask

  // Clock at 250 MHz.
  initial begin
    i_clk_sys = 1'b0;
    forever #2 i_clk_sys = ~i_clk_sys;
  end

  // Each load pulse takes the oldest note; a pulse with no note is wrong.
  always @(posedge i_clk_sys) begin
    if (o_load_done === 1'b1) begin
      if (exp_q.size() == 0) begin
        `CHK("load_done", 1'b0, o_load_done)
      end else begin
        exp_c = exp_q.pop_front();
        `CHK("ctrl_load", exp_c, o_ctrl)
      end
    end
  end

  // Watchdog at three times the expected run of about 50 us.
  initial begin
    #150000;
    bad_count++;
    end_sim();
  end

  // Main sequence: reset, documented modes, refusals, then random sweeps.
  initial begin
    bad_count = 0;
    n_tests = 0;
    a_cur = audio_path_pkg::CFG_A_RESET;
    b_cur = audio_path_pkg::CFG_B_RESET;
    a_stg = 16'h0000;
    pend = 1'b0;
    i_reset_n = 1'b0;
    void'($urandom(32'h2d72ce5b));
    repeat (16) @(posedge i_clk_sys);
    i_reset_n <= 1'b1;
    @(posedge i_clk_sys);
    #1;
    `CHK("ctrl_reset", decode(a_cur, b_cur), o_ctrl)
    `CHK("pending_reset", 1'b0, o_pending_a)
    repeat (4) @(posedge i_clk_sys);
    load(1'b0, 16'h440B, 16);
    load(1'b1, 16'h01E3, 16);
    load(1'b1, 16'h00C5, 16);
    load(1'b0, 16'h2421, 16);
    load(1'b1, 16'h0148, 16);
    load(1'b0, 16'h2424, 20);
    load(1'b1, 16'h59D1, 20);
    load(1'b0, 16'(~a_cur), 8);
    load(1'b1, 16'(~b_cur), 9);
    load(1'b0, 16'($urandom), 16);
    load(1'b0, 16'($urandom), 16);
    load(1'b1, 16'($urandom), 16);
    // Every attenuation and rate code, with random other fields.
    for (int k = 0; k < 8; k++) begin
      if (k[0]) load(1'b0, 16'($urandom), 16);
      load(1'b1, (16'($urandom) & 16'hC7F3) | 16'(k << 11) |
           16'((k & 3) << 2), 16);
    end
    `CHK("queue_empty", 0, exp_q.size())
    end_sim();
  end
endmodule // tb_audio_path_config_decode

`default_nettype wire
